// ---- testbench.sv ----
// Purpose: Self-checking bench for the exception unit.
// Assumes: 200 MHz clock; events are one-cycle pulses.
// Notes:   Software trap handlers are not modelled here.
module testbench
    import tte_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [2:0] k; logic [15:0] a; logic [7:0] v;
        logic [15:0] sv; logic [15:0] ps; logic p;} tte_row_t;
    logic sys_clk, reset_n, clk_en, op_done, op_halt, op_trap, op_rte;
    logic fault, frame_done, bkpt_trig, vack_done, vack_spurious, spur;
    logic [15:0] halt_imm, exc_saved_psw, processor_status_word;
    logic [3:0] trap_num, rte_format, delay, awaddr, araddr;
    logic [2:0] irq_level, vack_level;
    logic [7:0] vack_vector, exc_vector;
    logic exc_req, exc_pc_next, rte_ok, stopped, halted, vector_ack_cycle;
    logic irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int fails = 0;
    int num_checks = 0;
    tte_row_t rows[14] = '{'{0, 0, 8'h20, 16'h2700, 16'h2700, 1},
        '{0, 15, 8'h2F, 16'h2700, 16'h2700, 1},
        '{1, 3, 8'h0E, 16'h2700, 16'h2700, 1},
        '{1, 8, 8'h0E, 16'h2700, 16'h2700, 1},
        '{2, 16'hA700, 8'h09, 16'hA700, 16'h2700, 1},
        '{1, 4, 0, 0, 16'hA700, 1},
        '{4, 0, 8'h09, 16'hA700, 16'h2700, 1},
        '{1, 4, 0, 0, 16'hA700, 1},
        '{0, 1, 8'h21, 16'hA700, 16'h2700, 1},
        '{1, 4, 0, 0, 16'hA700, 1},
        '{2, 16'h2700, 8'h09, 16'hA700, 16'h2700, 0},
        '{2, 16'h2500, 8'h09, 16'h2500, 16'h2700, 1},
        '{2, 16'h1500, 0, 0, 16'h1500, 1},
        '{3, 0, 8'h0C, 16'h1500, 16'h3500, 1}};

    tte_exception_unit dut (.sys_clk, .reset_n, .clk_en, .op_done,
        .op_halt, .halt_imm, .op_trap, .trap_num, .op_rte, .rte_format,
        .fault, .frame_done, .bkpt_trig, .irq_level, .vack_done,
        .vack_vector, .vack_spurious, .exc_req, .exc_vector, .exc_pc_next,
        .exc_saved_psw, .processor_status_word, .rte_ok, .stopped, .halted,
        .vector_ack_cycle, .vack_level, .irq, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    tte_irq_src src (.sys_clk, .reset_n, .delay, .spur, .vector_ack_cycle,
        .vack_level, .vack_done, .vack_vector, .vack_spurious);

    // Free-running clock.
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Verdict and end of run.
    task conclude();
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // A wait that ran out ends the run.
    task gone(input logic ok);
        if (!ok) begin
            chk("wait", 0, 1);
            conclude();
        end
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d, logic [1:0] r);
        @(posedge sys_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        repeat (50) begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        gone(bvalid);
        chk("bresp", bresp, r);
        bready <= 1'b0;
    endtask

    task axi_rd(input logic [3:0] a, input logic [31:0] d, logic [1:0] r);
        @(posedge sys_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        repeat (50) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        gone(rvalid);
        chk("rdata", rdata, d);
        chk("rresp", rresp, r);
        rready <= 1'b0;
    endtask

    task fire(input logic [2:0] k, input logic [15:0] a);
        @(posedge sys_clk);
        {trap_num, rte_format, halt_imm} <= {a[3:0], a[3:0], a};
        {op_trap, op_rte, op_halt, bkpt_trig, op_done} <= 5'b10000 >> k;
        @(posedge sys_clk);
        {op_trap, op_rte, op_halt, bkpt_trig, op_done} <= 5'b00000;
    endtask

    // Take one frame; a trap offered mid-frame must be dropped.
    task take(input logic [7:0] v, input logic [15:0] sv, logic p = 1'b1);
        repeat (60) begin
            #1;
            if (exc_req === 1'b1) break;
            @(posedge sys_clk);
        end
        gone(exc_req === 1'b1);
        chk("vector", exc_vector, v);
        if (v == VEC_TRACE) chk("pc_next", exc_pc_next, p);
        chk("saved_psw", exc_saved_psw, sv);
        fire(0, 16'h0001);
        frame_done <= 1'b1;
        @(posedge sys_clk);
        frame_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("exc_req", exc_req, 0);
    endtask

    initial begin
        {reset_n, clk_en, op_done, op_halt, op_trap, op_rte, fault} = 7'h20;
        {frame_done, bkpt_trig, spur, irq_level, halt_imm} = '0;
        {trap_num, rte_format, awaddr, araddr, delay} = '0;
        {awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Ordinary events, one row each.
        foreach (rows[i]) begin
            fire(rows[i].k, rows[i].a);
            if (rows[i].v == 8'h00) begin
                repeat (2) @(posedge sys_clk);
                #1 chk("stopped", stopped, rows[i].k == 2);
            end else take(rows[i].v, rows[i].sv, rows[i].p);
            chk("psw", processor_status_word, rows[i].ps);
        end
        // Accepted return, traceless completion, frozen clock enable.
        fire(1, 4);
        #1 chk("rte_ok", rte_ok, 1);
        fire(4, 0);
        clk_en <= 1'b0;
        fire(0, 3);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk("exc_req", exc_req, 0);
        // Registers, sticky status, masking and the interrupt line.
        axi_wr(ADDR_MASK, 32'h0000_003F, RESP_OKAY);
        axi_rd(ADDR_STATUS, 32'h0000_000F, RESP_OKAY);
        axi_rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
        axi_wr(ADDR_MASK, 32'h0000_0004, RESP_OKAY);
        fire(0, 16'h0007);
        take(8'h27, 16'h1500);
        chk("irq", irq, 1);
        axi_rd(ADDR_STATUS, 32'h0000_0004, RESP_OKAY);
        #1 chk("irq", irq, 0);
        axi_wr(ADDR_PSW, 32'h0000_0000, RESP_OKAY);
        axi_rd(ADDR_PSW, 32'h0000_3500, RESP_OKAY);
        axi_rd(4'h2, 32'h0000_0000, RESP_SLVERR);
        axi_wr(4'h2, 32'h0000_0001, RESP_SLVERR);
        axi_wr(ADDR_AVEC, 32'h0000_00FF, RESP_OKAY);
        axi_rd(ADDR_AVEC, 32'h0000_00FE, RESP_OKAY);
        axi_wr(ADDR_AVEC, 32'h0000_0020, RESP_OKAY);
        // Fetched vector with a slow source, then autovector, spurious.
        delay <= 4'h5;
        fire(2, 16'h2000);
        irq_level <= 3'h3;
        repeat (20) if (vector_ack_cycle !== 1'b1) @(posedge sys_clk);
        gone(vector_ack_cycle === 1'b1);
        chk("vack_level", vack_level, 3);
        take(8'h43, 16'h2000);
        chk("psw", processor_status_word, 16'h2300);
        fire(2, 16'h2000);
        irq_level <= 3'h5;
        take(8'h1D, 16'h2000);
        {delay, spur} <= 5'h01;
        fire(2, 16'h2000);
        irq_level <= 3'h2;
        take(VEC_SPURIOUS, 16'h2000);
        irq_level <= 3'h0;
        // Fault inside a frame halts until reset, then reset values.
        fire(0, 16'h0002);
        fault <= 1'b1;
        @(posedge sys_clk);
        fault <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chk("halted", halted, 1);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("halted", halted, 0);
        chk("psw", processor_status_word, PSW_RESET);
        chk("awready", awready, 1);
        conclude();
    end
endmodule // testbench

// ---- tte_exception_unit.sv ----
// Purpose: Exception selection for trace, debug, trap, return and irq.
// Assumes: Pipeline and interrupt logic share sys_clk; one frame at a time.
// Notes:   A fault during a vector fetch or frame build halts until reset.
//
// What this block does
// - Single-step flag traces every completed instruction.
// - Halt op under single-step traces first, pc here.
// - On return, halt op loads word, traces past.
// - Halt op setting single-step loads, traces past.
// - One exception frame per event, no stacking.
// - Breakpoint trigger gives debug vector 12 internally.
// - Debug entry keeps master flag and mask.
// - Return op checks the 4-bit frame format first.
// - Software trap excepts unless a breakpoint, interrupt, stop or frame is pending; enters supervisor.
// - Interrupts fetch 8-bit vector, spurious handled.
// - Autovectoring selectable by integration unit configuration.
// - Fault during exception processing halts until reset.
//
// Chosen here: the register addresses and the AXI4-Lite register port.

// ----------------------------------------------------------------------
// Top module
// ----------------------------------------------------------------------
module tte_exception_unit
    import tte_pkg::*;
(
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Pipeline events.
    input wire logic op_done,
    input wire logic op_halt,
    input wire logic [15:0] halt_imm,
    input wire logic op_trap,
    input wire logic [3:0] trap_num,
    input wire logic op_rte,
    input wire logic [3:0] rte_format,
    input wire logic fault,
    input wire logic frame_done,
    // Breakpoint and interrupt sources.
    input wire logic bkpt_trig,
    input wire logic [2:0] irq_level,
    input wire logic vack_done,
    input wire logic [7:0] vack_vector,
    input wire logic vack_spurious,
    // Exception outputs to the pipeline.
    output logic exc_req,
    output logic [7:0] exc_vector,
    output logic exc_pc_next,
    output logic [15:0] exc_saved_psw,
    output logic [15:0] processor_status_word,
    output logic rte_ok,
    output logic stopped,
    output logic halted,
    // Vector acknowledge cycle request.
    output logic vector_ack_cycle,
    output logic [2:0] vack_level,
    // Interrupt to the system.
    output logic irq,
    // AXI4-Lite slave.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Maps a byte address onto a register select code.
    function automatic logic [2:0] reg_sel(input logic [3:0] a);
        if (a == ADDR_AVEC) reg_sel = SEL_AVEC;
        else if (a == ADDR_STATUS) reg_sel = SEL_STATUS;
        else if (a == ADDR_MASK) reg_sel = SEL_MASK;
        else if (a == ADDR_PSW) reg_sel = SEL_PSW;
        else reg_sel = SEL_NONE;
    endfunction

    tte_state_t state_reg, state_next;
    logic [15:0] psw_reg, psw_next, saved_reg, saved_next;
    logic [7:0] vec_reg, vec_next, avec_reg;
    logic pcn_reg, pcn_next, resume_reg, resume_next, rte_ok_next;
    logic [2:0] lvl_reg, lvl_next;
    logic [EV_W-1:0] ev, status_reg, status_next, mask_reg;
    logic take, t_pcn;
    logic [7:0] t_vec;
    logic [15:0] t_base;
    logic [2:0] t_ipl;
    logic t_irq;

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    // Level 7 cannot be masked; other levels must beat the current mask.
    wire [2:0] ipl = psw_reg[PSW_IPL_LO+2:PSW_IPL_LO];
    wire t_on = psw_reg[PSW_T];
    wire irq_hit = irq_level != 3'h0 &&
        (irq_level == 3'h7 || irq_level > ipl);
    wire fmt_ok = rte_format >= FMT_MIN && rte_format <= FMT_MAX;
    wire [7:0] auto_vec = VEC_AUTO_BASE + {5'h00, irq_level};
    wire [7:0] trap_vec = VEC_TRAP_BASE + {4'h0, trap_num};

    // ------------------------------------------------------------------
    // Exception selection
    // ------------------------------------------------------------------
    // Only one source wins per cycle and nothing is queued, so a lower
    // source seen together with a higher one is simply not taken.
    always_comb begin
        state_next = state_reg;
        psw_next = psw_reg;
        resume_next = resume_reg;
        lvl_next = lvl_reg;
        rte_ok_next = 1'b0;
        take = 1'b0;
        t_vec = VEC_TRACE;
        t_pcn = 1'b0;
        t_base = psw_reg;
        t_ipl = ipl;
        t_irq = 1'b0;
        ev = '0;
        case (state_reg)
            ST_RUN, ST_STOP: begin
                if (bkpt_trig) begin
                    take = 1'b1;
                    t_vec = VEC_DEBUG;
                end else if (irq_hit) begin
                    if (avec_reg[irq_level]) begin
                        take = 1'b1;
                        t_irq = 1'b1;
                        t_vec = auto_vec;
                        t_ipl = irq_level;
                    end else begin
                        state_next = ST_VACK;
                        lvl_next = irq_level;
                    end
                end else if (state_reg == ST_STOP) begin
                    state_next = ST_STOP;
                end else if (op_trap) begin
                    take = 1'b1;
                    t_vec = trap_vec;
                    t_pcn = 1'b1;
                end else if (op_rte) begin
                    if (fmt_ok) begin
                        rte_ok_next = 1'b1;
                        // An accepted return restores the stacked word.
                        psw_next = saved_reg;
                    end else begin
                        take = 1'b1;
                        t_vec = VEC_FORMAT;
                    end
                end else if (op_halt) begin
                    if (t_on && !resume_reg) begin
                        take = 1'b1;
                        resume_next = 1'b1;
                    end else begin
                        // Word is loaded before the trace is raised.
                        psw_next = halt_imm;
                        t_base = halt_imm;
                        resume_next = 1'b0;
                        if (resume_reg || halt_imm[PSW_T]) begin
                            take = 1'b1;
                            t_pcn = 1'b1;
                        end else begin
                            state_next = ST_STOP;
                        end
                    end
                end else if (op_done && t_on) begin
                    take = 1'b1;
                    t_pcn = 1'b1;
                end
            end
            ST_VACK: begin
                if (fault) begin
                    state_next = ST_HALT;
                    ev[EV_DBLF] = 1'b1;
                end else if (vack_done) begin
                    take = 1'b1;
                    t_irq = 1'b1;
                    t_ipl = lvl_reg;
                    t_vec = vack_spurious ? VEC_SPURIOUS : vack_vector;
                end
            end
            ST_FRAME: begin
                if (fault) begin
                    state_next = ST_HALT;
                    ev[EV_DBLF] = 1'b1;
                end else if (frame_done) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_HALT;
        endcase
        if (take) begin
            state_next = ST_FRAME;
            psw_next = t_base;
            psw_next[PSW_S] = 1'b1;
            psw_next[PSW_T] = 1'b0;
            // Debug entry leaves the master flag and mask alone.
            psw_next[PSW_IPL_LO+2:PSW_IPL_LO] = t_ipl;
            ev[EV_TRACE] = t_vec == VEC_TRACE && !t_irq;
            ev[EV_DEBUG] = t_vec == VEC_DEBUG && !t_irq;
            ev[EV_TRAP] = op_trap && t_vec == trap_vec && !t_irq;
            ev[EV_FORMAT] = t_vec == VEC_FORMAT && !t_irq;
            ev[EV_IRQ] = t_irq;
        end
    end

    assign vec_next = take ? t_vec : vec_reg;
    assign pcn_next = take ? t_pcn : pcn_reg;
    assign saved_next = take ? t_base : saved_reg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic aw_have, w_have;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire b_hs = s_axi_bvalid && s_axi_bready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire r_hs = s_axi_rvalid && s_axi_rready;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid;
    wire [2:0] wsel = reg_sel(aw_addr);
    wire [2:0] rsel = reg_sel(s_axi_araddr);
    wire wr_avec = wr_fire && wsel == SEL_AVEC && w_strb[0];
    wire wr_mask = wr_fire && wsel == SEL_MASK && w_strb[0];
    // A read of the status register clears it, but a new event wins.
    wire rd_clr = ar_hs && rsel == SEL_STATUS;
    assign status_next = (rd_clr ? '0 : status_reg) | ev;
    wire [31:0] rd_mux =
        rsel == SEL_AVEC ? {24'h00_0000, avec_reg} :
        rsel == SEL_STATUS ? {26'h000_0000, status_reg} :
        rsel == SEL_MASK ? {26'h000_0000, mask_reg} :
        {16'h0000, psw_reg};

    // Bus handshakes; address and data may arrive in either order.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            avec_reg <= 8'h00;
            mask_reg <= '0;
        end else if (clk_en) begin
            if (aw_hs) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_have <= 1'b0;
            end
            if (w_hs) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_have <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wsel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
            end else if (b_hs) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (wr_avec) avec_reg <= {w_data[7:1], 1'b0};
            if (wr_mask) mask_reg <= w_data[EV_W-1:0];
            if (ar_hs) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rsel == SEL_NONE ? 32'h0000_0000 : rd_mux;
                s_axi_rresp <= rsel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
            end else if (r_hs) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Core state and outputs
    // ------------------------------------------------------------------
    // Outputs are separate flops so the pipeline sees no decode glitches.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_RUN;
            psw_reg <= PSW_RESET;
            saved_reg <= PSW_RESET;
            vec_reg <= 8'h00;
            pcn_reg <= 1'b0;
            resume_reg <= 1'b0;
            lvl_reg <= 3'h0;
            status_reg <= '0;
            rte_ok <= 1'b0;
            exc_req <= 1'b0;
            stopped <= 1'b0;
            halted <= 1'b0;
            vector_ack_cycle <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            psw_reg <= psw_next;
            saved_reg <= saved_next;
            vec_reg <= vec_next;
            pcn_reg <= pcn_next;
            resume_reg <= resume_next;
            lvl_reg <= lvl_next;
            status_reg <= status_next;
            rte_ok <= rte_ok_next;
            exc_req <= state_next == ST_FRAME;
            stopped <= state_next == ST_STOP;
            halted <= state_next == ST_HALT;
            vector_ack_cycle <= state_next == ST_VACK;
            irq <= |(status_next & mask_reg);
        end
    end

    assign exc_vector = vec_reg;
    assign exc_pc_next = pcn_reg;
    assign exc_saved_psw = saved_reg;
    assign processor_status_word = psw_reg;
    assign vack_level = lvl_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    wire quiet = clk_en && state_reg == ST_RUN && !bkpt_trig && !irq_hit;
    wire plain = quiet && !op_trap && !op_rte;

    property p_trace_step;
        plain && !op_halt && op_done && t_on |=>
            exc_req && exc_vector == VEC_TRACE && exc_pc_next;
    endproperty
    a_trace_step: assert property (p_trace_step)
        else $error("single step did not trace");

    property p_halt_first;
        plain && op_halt && t_on && !resume_reg |=>
            exc_req && !exc_pc_next && resume_reg;
    endproperty
    a_halt_first: assert property (p_halt_first)
        else $error("halt op under step did not trace first");

    property p_halt_resume;
        plain && op_halt && resume_reg |=>
            exc_pc_next && exc_saved_psw == $past(halt_imm) && !resume_reg;
    endproperty
    a_halt_resume: assert property (p_halt_resume)
        else $error("halt op resume trace wrong");

    property p_halt_set;
        plain && op_halt && !t_on && !resume_reg && halt_imm[PSW_T] |=>
            exc_req && exc_pc_next && exc_vector == VEC_TRACE;
    endproperty
    a_halt_set: assert property (p_halt_set)
        else $error("halt op setting step did not trace");

    sequence s_frame_open;
        clk_en && exc_req && !frame_done && !fault;
    endsequence
    property p_one_frame;
        s_frame_open |=> exc_req && $stable(exc_vector);
    endproperty
    a_one_frame: assert property (p_one_frame)
        else $error("frame disturbed while open");

    property p_debug;
        clk_en && state_reg == ST_RUN && bkpt_trig |=>
            exc_vector == VEC_DEBUG && !vector_ack_cycle &&
            processor_status_word[PSW_M] == $past(psw_reg[PSW_M]) &&
            processor_status_word[PSW_IPL_LO+2:PSW_IPL_LO] == $past(ipl);
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug entry wrong");

    property p_rte;
        plain && op_rte |=> ($past(fmt_ok) ? rte_ok && !exc_req :
            exc_req && exc_vector == VEC_FORMAT);
    endproperty
    a_rte: assert property (p_rte)
        else $error("return format check wrong");

    property p_trap;
        quiet && op_trap |=> exc_vector == $past(trap_vec) &&
            processor_status_word[PSW_S];
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap did not enter supervisor");

    sequence s_vack_done;
        clk_en && vector_ack_cycle && vack_done && !fault;
    endsequence
    property p_vack;
        s_vack_done |=> exc_req && exc_vector ==
            ($past(vack_spurious) ? VEC_SPURIOUS : $past(vack_vector));
    endproperty
    a_vack: assert property (p_vack)
        else $error("vector fetch result wrong");

    property p_dblf;
        clk_en && exc_req && fault |=> halted ##1 halted ##1 halted;
    endproperty
    a_dblf: assert property (p_dblf)
        else $error("double fault did not halt");

endmodule // tte_exception_unit

// ---- tte_irq_src.sv ----
// Purpose: Behavioural interrupt source answering vector fetch cycles.
// Assumes: Shares sys_clk with the unit; one answer per fetch request.
// Notes:   Vector is 0x40 plus level; idle data toggles every cycle.
module tte_irq_src (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bench controls.
    input wire logic [3:0] delay,
    input wire logic spur,
    // Vector fetch handshake.
    input wire logic vector_ack_cycle,
    input wire logic [2:0] vack_level,
    output logic vack_done,
    output logic [7:0] vack_vector,
    output logic vack_spurious
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_reg;
    logic busy_reg;

    // Answer once after the delay, then idle until the request drops.
    // Released lines toggle so a stale vector never looks fresh.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg <= 4'h0;
            busy_reg <= 1'b0;
            vack_done <= 1'b0;
            vack_vector <= 8'h5A;
            vack_spurious <= 1'b0;
        end else begin
            vack_done <= 1'b0;
            vack_vector <= ~vack_vector;
            vack_spurious <= ~vack_spurious;
            if (!vector_ack_cycle) begin
                wait_reg <= 4'h0;
                busy_reg <= 1'b0;
            end else if (!busy_reg && wait_reg == delay) begin
                vack_done <= 1'b1;
                vack_vector <= 8'h40 + {5'h00, vack_level};
                vack_spurious <= spur;
                busy_reg <= 1'b1;
            end else if (!busy_reg) begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule // tte_irq_src

// ---- tte_pkg.sv ----
// Purpose: Shared constants for the trace and trap exception unit.
// Assumes: One core clock; register bus is AXI4-Lite with 32-bit data.
// Notes:   Vector numbers other than the debug vector are plain defaults.

// ----------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------
package tte_pkg;
    // Register byte offsets.
    localparam logic [3:0] ADDR_AVEC = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam logic [3:0] ADDR_PSW = 4'hC;
    // Status word fields and value after reset.
    localparam int PSW_T = 15;
    localparam int PSW_S = 13;
    localparam int PSW_M = 12;
    localparam int PSW_IPL_LO = 8;
    localparam logic [15:0] PSW_RESET = 16'h2700;
    // Vector numbers.
    localparam logic [7:0] VEC_TRACE = 8'h09;
    localparam logic [7:0] VEC_DEBUG = 8'h0C;
    localparam logic [7:0] VEC_FORMAT = 8'h0E;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
    // Return frame formats accepted by the return instruction.
    localparam logic [3:0] FMT_MIN = 4'h4;
    localparam logic [3:0] FMT_MAX = 4'h7;
    // Event status bit positions.
    localparam int EV_TRACE = 0;
    localparam int EV_DEBUG = 1;
    localparam int EV_TRAP = 2;
    localparam int EV_FORMAT = 3;
    localparam int EV_IRQ = 4;
    localparam int EV_DBLF = 5;
    localparam int EV_W = 6;
    // Register select codes and bus responses.
    localparam logic [2:0] SEL_AVEC = 3'h0;
    localparam logic [2:0] SEL_STATUS = 3'h1;
    localparam logic [2:0] SEL_MASK = 3'h2;
    localparam logic [2:0] SEL_PSW = 3'h3;
    localparam logic [2:0] SEL_NONE = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_VACK = 3'b001,
        ST_FRAME = 3'b010,
        ST_STOP = 3'b011,
        ST_HALT = 3'b100
    } tte_state_t;
endpackage
